// ### eeio_core_model.sv
// Processor core model issuing register port accesses
`default_nettype none

module eeio_core_model (
  // Clock
  input wire logic clock_i,
  // Register port towards the block
  output logic bus_wr_o,
  output logic bus_rd_o,
  output var eeio_pkg::eeio_bus_t bus_req_o,
  input wire logic [7:0] bus_rdata_i,
  input wire logic stall_i
);
  timeunit 1ns;
  timeprecision 100ps;

  int stall_n;

  initial begin
    bus_wr_o = 1'b0;
    bus_rd_o = 1'b0;
    bus_req_o = '0;
    stall_n = 0;
  end

  // ---------------------------------------------------------------
  // One access, then halt for as long as the block stalls the core
  // ---------------------------------------------------------------
  task automatic acc(input logic wr, input logic io, input logic [1:0] op,
      input logic [2:0] b, input logic [11:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge clock_i);
    bus_wr_o <= wr;
    bus_rd_o <= ~wr;
    bus_req_o <= '{io, eeio_pkg::eeio_bop_t'(op), b, a, d};
    @(posedge clock_i);
    bus_wr_o <= 1'b0;
    bus_rd_o <= 1'b0;
    #1;
    q = bus_rdata_i;
    stall_n = 0;
    // Never issue while halted
    while (stall_i === 1'b1 && stall_n < 64) begin
      stall_n++;
      @(posedge clock_i);
      #1;
    end
  endtask : acc

endmodule : eeio_core_model

`default_nettype wire

// ### eeio_ctrl.sv
// Byte store access control, I/O register map and programming engine
//
// How it works
// - A data SRAM access finishes in two CPU cycles.
// - The store is a separate byte-addressed space, each byte alone.
// - Pointer, value and control registers sit in I/O space.
// - A read strobe stalls the core for four cycles.
// - A program start stalls the core for two cycles.
// - Select 00 with armed strobe: erase and write the pointed byte.
// - program_strobe stays set while busy, clears itself at the end.
// - While programming, every other store operation is refused.
// - Select 01 with armed strobe: erase only.
// - Select 10 with armed strobe: write value register only.
// - Programming time is counted on the calibrated oscillator.
// - A running program operation survives system reset if supply holds.
// - I/O addresses 0x00-0x1F allow bit set, clear and test.
// - Port I/O reaches 0x00-0x3F, seen in data space at +0x20.
// - Data addresses 0x60-0xFF only through data-space access.
// - Some flags clear on writing one; zero leaves them.
// - Bit set and clear touch only the addressed bit.
// - Three general registers; bit-accessible ones allow bit operations.
// - program_arm clears after four cycles; unarmed strobe does nothing.
// - Select writes are ignored while program_strobe is set.
// - Ready interrupt is a level while enabled and idle.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`default_nettype none

// ---------------------------------------------------------------
// Programming engine, kept alive across system reset
// ---------------------------------------------------------------
module eeio_prog #(
  parameter int ADDR_W = 9,
  parameter int DEPTH = 512,
  parameter int ATOMIC_TICKS = eeio_pkg::osc_ticks(eeio_pkg::ATOMIC_US),
  parameter int SPLIT_TICKS = eeio_pkg::osc_ticks(eeio_pkg::SPLIT_US)
) (
  // Clock and power-on reset
  input wire logic clock_i,
  input wire logic por_ni,
  // Pins
  input wire logic osc_clk_i,
  input wire logic supply_ok_i,
  // Requests
  input wire logic start_i,
  input wire eeio_pkg::eeio_sel_t sel_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic [ADDR_W-1:0] raddr_i,
  // Status and read port
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o
);
  localparam int CNT_W = $clog2(ATOMIC_TICKS + 1);

  typedef enum logic {PG_IDLE = 1'b0, PG_RUN = 1'b1} eeio_pg_t;

  typedef struct packed {
    logic [2:0] osc;
    logic [1:0] sup;
    eeio_pg_t st;
    eeio_pkg::eeio_sel_t sel;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic [CNT_W-1:0] cnt;
    logic done;
    logic [DEPTH-1:0][7:0] mem;
  } eeio_pgst_t;

  eeio_pgst_t pg_ff;
  eeio_pgst_t nxt_pg;
  logic tick;

  always_comb begin
    nxt_pg = pg_ff;
    nxt_pg.osc = {pg_ff.osc[1:0], osc_clk_i};
    nxt_pg.sup = {pg_ff.sup[0], supply_ok_i};
    nxt_pg.done = 1'b0;
    tick = pg_ff.osc[1] & ~pg_ff.osc[2];
    unique case (pg_ff.st)
      PG_IDLE: begin
        if (start_i) begin
          nxt_pg.st = PG_RUN;
          nxt_pg.sel = sel_i;
          nxt_pg.addr = addr_i;
          nxt_pg.data = data_i;
          nxt_pg.cnt = (sel_i == eeio_pkg::SEL_ATOMIC) ?
            CNT_W'(ATOMIC_TICKS) : CNT_W'(SPLIT_TICKS);
        end
      end
      PG_RUN: begin
        if (!pg_ff.sup[1]) begin
          // Supply lost: abandon, byte left as it was
          nxt_pg.st = PG_IDLE;
          nxt_pg.done = 1'b1;
        end else if (tick) begin
          if (pg_ff.cnt == CNT_W'(1)) begin
            nxt_pg.st = PG_IDLE;
            nxt_pg.done = 1'b1;
            unique case (pg_ff.sel)
              eeio_pkg::SEL_ATOMIC: nxt_pg.mem[pg_ff.addr] = pg_ff.data;
              eeio_pkg::SEL_ERASE:
                nxt_pg.mem[pg_ff.addr] = eeio_pkg::ERASED_BYTE;
              // Unerased target ends up as a wired AND, i.e. unusable
              eeio_pkg::SEL_WRITE:
                nxt_pg.mem[pg_ff.addr] =
                  pg_ff.mem[pg_ff.addr] & pg_ff.data;
              default: nxt_pg.mem = pg_ff.mem;
            endcase
          end else begin
            nxt_pg.cnt = pg_ff.cnt - CNT_W'(1);
          end
        end
      end
    endcase
  end

  // Only power-on clears it, so system reset never cuts a program cycle
  always_ff @(posedge clock_i or negedge por_ni) begin
    if (!por_ni) begin
      pg_ff <= '0;
    end else begin
      pg_ff <= nxt_pg;
    end
  end

  assign busy_o = (pg_ff.st == PG_RUN);
  assign done_o = pg_ff.done;
  assign rdata_o = pg_ff.mem[raddr_i];

  // Count may only move on an oscillator edge, never on the CPU clock
  AST_OSC_TIMED: assert property (
    @(posedge clock_i) disable iff (!por_ni)
    busy_o && pg_ff.sup[1] && !tick |=> busy_o && $stable(pg_ff.cnt))
    else $error("program count moved without an oscillator edge");

endmodule : eeio_prog

// ---------------------------------------------------------------
// Register map, strobes and core stall
// ---------------------------------------------------------------
module eeio_ctrl #(
  parameter int ADDR_W = 9,
  parameter int DEPTH = 512,
  parameter int SRAM_DEPTH = 16,
  parameter int ATOMIC_TICKS = eeio_pkg::osc_ticks(eeio_pkg::ATOMIC_US),
  parameter int SPLIT_TICKS = eeio_pkg::osc_ticks(eeio_pkg::SPLIT_US)
) (
  // Clock and resets
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic por_ni,
  // Register port
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire eeio_pkg::eeio_bus_t bus_req_i,
  output logic [7:0] bus_rdata_o,
  // Core stall and ready interrupt
  output logic stall_o,
  output logic nvm_ready_irq_o,
  // Pins
  input wire logic osc_clk_i,
  input wire logic supply_ok_i
);
  localparam int SRAM_W = $clog2(SRAM_DEPTH);

  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] gpr0;
    logic [7:0] gpr1;
    logic [7:0] gpr2;
    logic [ADDR_W-1:0] ptr;
    logic [7:0] value;
    eeio_pkg::eeio_sel_t sel;
    logic irq_en;
    logic [2:0] arm_cnt;
    logic [2:0] stall_cnt;
    logic [1:0] flags;
    logic [7:0] refused;
    logic [SRAM_DEPTH-1:0][7:0] sram;
  } eeio_st_t;

  eeio_st_t st_ff;
  eeio_st_t nxt_st;
  logic busy;
  logic done;
  logic [7:0] eng_rdata;
  logic start;
  logic rd_trig;
  logic arm_wr;
  logic prog_wr;
  logic refuse;
  logic sram_hit;
  logic acc_ok;
  logic [11:0] dadr;
  logic [7:0] old;
  logic [7:0] wval;
  logic [7:0] ones;
  logic [7:0] ctrl_view;

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    return 8'h01 << b;
  endfunction : bit_mask

  function automatic logic [7:0] read_reg(input eeio_st_t s,
      input logic [11:0] a, input logic bsy);
    logic [7:0] r;
    r = eeio_pkg::BYTE_RESET;
    if (a >= eeio_pkg::SRAM_BASE &&
        a < eeio_pkg::SRAM_BASE + 12'(SRAM_DEPTH)) begin
      r = s.sram[SRAM_W'(a - eeio_pkg::SRAM_BASE)];
    end else begin
      unique case (a)
        eeio_pkg::ADR_GPR0: r = s.gpr0;
        eeio_pkg::ADR_GPR1: r = s.gpr1;
        eeio_pkg::ADR_GPR2: r = s.gpr2;
        eeio_pkg::ADR_VALUE: r = s.value;
        eeio_pkg::ADR_PTR_LO: r = s.ptr[7:0];
        eeio_pkg::ADR_PTR_HI: r = 8'(s.ptr[ADDR_W-1:8]);
        eeio_pkg::ADR_FLAGS: r = 8'(s.flags);
        eeio_pkg::ADR_REFUSED: r = s.refused;
        eeio_pkg::ADR_CTRL: begin
          r[eeio_pkg::CTL_SEL +: 2] = s.sel;
          r[eeio_pkg::CTL_IRQEN] = s.irq_en;
          r[eeio_pkg::CTL_ARM] = (s.arm_cnt != 3'h0);
          r[eeio_pkg::CTL_PROG] = bsy;
        end
        default: r = eeio_pkg::BYTE_RESET;
      endcase
    end
    return r;
  endfunction : read_reg

  eeio_prog #(
    .ADDR_W(ADDR_W),
    .DEPTH(DEPTH),
    .ATOMIC_TICKS(ATOMIC_TICKS),
    .SPLIT_TICKS(SPLIT_TICKS)
  ) u_prog (
    .clock_i(clock_i),
    .por_ni(por_ni),
    .osc_clk_i(osc_clk_i),
    .supply_ok_i(supply_ok_i),
    .start_i(start),
    .sel_i(st_ff.sel),
    .addr_i(st_ff.ptr),
    .data_i(st_ff.value),
    .raddr_i(st_ff.ptr),
    .busy_o(busy),
    .done_o(done),
    .rdata_o(eng_rdata)
  );

  always_comb begin
    nxt_st = st_ff;
    start = 1'b0;
    rd_trig = 1'b0;
    arm_wr = 1'b0;
    prog_wr = 1'b0;
    refuse = 1'b0;
    sram_hit = 1'b0;
    // Port space is shifted up; data space addressed as is
    dadr = bus_req_i.io_space ?
      bus_req_i.addr + eeio_pkg::IO_DATA_OFFSET : bus_req_i.addr;
    // Port space above 0x3F cannot exist, so extended regs stay unreachable
    acc_ok = !bus_req_i.io_space ||
      (bus_req_i.addr <= eeio_pkg::IO_PORT_LAST);
    if (bus_req_i.bop != eeio_pkg::BOP_BYTE) begin
      acc_ok = acc_ok && bus_req_i.io_space &&
        (bus_req_i.addr <= eeio_pkg::IO_BIT_LAST);
    end
    old = read_reg(st_ff, dadr, busy);
    unique case (bus_req_i.bop)
      eeio_pkg::BOP_SET: begin
        wval = old | bit_mask(bus_req_i.bit_sel);
        ones = bit_mask(bus_req_i.bit_sel);
      end
      eeio_pkg::BOP_CLR: begin
        wval = old & ~bit_mask(bus_req_i.bit_sel);
        ones = 8'h00;
      end
      eeio_pkg::BOP_TEST: begin
        wval = old;
        ones = 8'h00;
      end
      eeio_pkg::BOP_BYTE: begin
        wval = bus_req_i.wdata;
        ones = bus_req_i.wdata;
      end
    endcase
    if (st_ff.arm_cnt != 3'h0) begin
      nxt_st.arm_cnt = st_ff.arm_cnt - 3'h1;
    end
    if (st_ff.stall_cnt != 3'h0) begin
      nxt_st.stall_cnt = st_ff.stall_cnt - 3'h1;
    end
    if (bus_rd_i && acc_ok) begin
      nxt_st.rdata = (bus_req_i.bop == eeio_pkg::BOP_TEST) ?
        8'(old[bus_req_i.bit_sel]) : old;
    end
    if (bus_wr_i && acc_ok && bus_req_i.bop != eeio_pkg::BOP_TEST) begin
      if (dadr >= eeio_pkg::SRAM_BASE &&
          dadr < eeio_pkg::SRAM_BASE + 12'(SRAM_DEPTH)) begin
        sram_hit = 1'b1;
      end else begin
        unique case (dadr)
          eeio_pkg::ADR_GPR0: nxt_st.gpr0 = wval;
          eeio_pkg::ADR_GPR1: nxt_st.gpr1 = wval;
          eeio_pkg::ADR_GPR2: nxt_st.gpr2 = wval;
          eeio_pkg::ADR_VALUE: nxt_st.value = wval;
          eeio_pkg::ADR_PTR_LO: begin
            if (busy) begin
              refuse = 1'b1;
            end else begin
              nxt_st.ptr[7:0] = wval;
            end
          end
          eeio_pkg::ADR_PTR_HI: begin
            if (busy) begin
              refuse = 1'b1;
            end else begin
              nxt_st.ptr[ADDR_W-1:8] = wval[ADDR_W-9:0];
            end
          end
          eeio_pkg::ADR_FLAGS: begin
            nxt_st.flags = st_ff.flags & ~ones[1:0];
          end
          eeio_pkg::ADR_CTRL: begin
            nxt_st.irq_en = wval[eeio_pkg::CTL_IRQEN];
            if (!busy) begin
              nxt_st.sel = eeio_pkg::eeio_sel_t'(wval[eeio_pkg::CTL_SEL +: 2]);
            end
            arm_wr = ones[eeio_pkg::CTL_ARM];
            prog_wr = ones[eeio_pkg::CTL_PROG];
            rd_trig = ones[eeio_pkg::CTL_READ] && !busy;
            if ((prog_wr || ones[eeio_pkg::CTL_READ]) && busy) begin
              refuse = 1'b1;
            end
            start = prog_wr && !busy && (st_ff.arm_cnt != 3'h0) &&
              (st_ff.sel != eeio_pkg::SEL_RSVD);
          end
          default: nxt_st.rdata = st_ff.rdata;
        endcase
      end
    end
    if (sram_hit) begin
      nxt_st.sram[SRAM_W'(dadr - eeio_pkg::SRAM_BASE)] = wval;
    end
    if ((bus_wr_i || bus_rd_i) && acc_ok && !bus_req_i.io_space &&
        dadr >= eeio_pkg::SRAM_BASE &&
        dadr < eeio_pkg::SRAM_BASE + 12'(SRAM_DEPTH)) begin
      nxt_st.stall_cnt = eeio_pkg::SRAM_STALL;
    end
    if (arm_wr) begin
      nxt_st.arm_cnt = eeio_pkg::ARM_CYCLES;
    end
    if (start) begin
      nxt_st.arm_cnt = 3'h0;
      nxt_st.stall_cnt = eeio_pkg::PROG_STALL;
    end
    if (rd_trig) begin
      nxt_st.value = eng_rdata;
      nxt_st.stall_cnt = eeio_pkg::READ_STALL;
    end
    if (refuse) begin
      nxt_st.refused = st_ff.refused + 8'h01;
    end
    // Hardware set after the clear, so a same-cycle event is kept
    if (done) begin
      nxt_st.flags[eeio_pkg::FLG_DONE] = 1'b1;
    end
    if (refuse) begin
      nxt_st.flags[eeio_pkg::FLG_REFUSED] = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus_rdata_o = st_ff.rdata;
  assign stall_o = (st_ff.stall_cnt != 3'h0);
  assign nvm_ready_irq_o = st_ff.irq_en && !busy;
  assign ctrl_view = read_reg(st_ff, eeio_pkg::ADR_CTRL, busy);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  AST_READ_STALL: assert property (
    rd_trig |=> stall_o [*4] ##1 !stall_o)
    else $error("read stall is not four cycles");
  AST_PROG_STALL: assert property (
    start |=> stall_o [*2] ##1 !stall_o)
    else $error("program stall is not two cycles");
  AST_SRAM_STALL: assert property (
    sram_hit |=> stall_o ##1 !stall_o)
    else $error("sram access not two cycles");
  AST_ARM_WINDOW: assert property (
    arm_wr && !start ##1 (!arm_wr && !start) [*4] |->
      (st_ff.arm_cnt != 3'h0) ##1 (st_ff.arm_cnt == 3'h0))
    else $error("arm window not four cycles");
  AST_NO_UNARMED: assert property (
    prog_wr && st_ff.arm_cnt == 3'h0 |-> !start)
    else $error("unarmed strobe started programming");
  AST_START_BUSY: assert property (
    start |=> busy && ctrl_view[eeio_pkg::CTL_PROG])
    else $error("program bit not set after start");
  AST_NO_OVERLAP: assert property (
    busy |-> !start && !rd_trig)
    else $error("operation accepted while busy");
  AST_PTR_HOLD: assert property (
    busy && bus_wr_i && dadr == eeio_pkg::ADR_PTR_LO |=> $stable(st_ff.ptr))
    else $error("pointer changed while busy");
  AST_SEL_HOLD: assert property (
    busy && bus_wr_i && dadr == eeio_pkg::ADR_CTRL |=> $stable(st_ff.sel))
    else $error("select changed while busy");
  AST_READ_LOAD: assert property (
    rd_trig |=> st_ff.value == $past(eng_rdata))
    else $error("read byte not loaded");
  AST_W1C_ZERO: assert property (
    bus_wr_i && dadr == eeio_pkg::ADR_FLAGS && ones == 8'h00 && !done &&
      !refuse |=> $stable(st_ff.flags))
    else $error("zero write changed a flag");

  COV_ATOMIC: cover property (start && st_ff.sel == eeio_pkg::SEL_ATOMIC);
  COV_ERASE: cover property (start && st_ff.sel == eeio_pkg::SEL_ERASE);
  COV_READ: cover property (rd_trig ##5 bus_rd_i);
  COV_REFUSE: cover property (refuse);

endmodule : eeio_ctrl

`default_nettype wire

// ### eeio_pkg.sv
// Shared constants and types of the nonvolatile byte store access block
`default_nettype none

package eeio_pkg;

  // ---------------------------------------------------------------
  // Address space layout (port limits in I/O addresses, SRAM base in data space)
  // ---------------------------------------------------------------
  localparam int DATA_ADDR_W = 12;
  localparam logic [11:0] IO_DATA_OFFSET = 12'h020;
  localparam logic [11:0] IO_PORT_LAST = 12'h03F;
  localparam logic [11:0] IO_BIT_LAST = 12'h01F;
  localparam logic [11:0] SRAM_BASE = 12'h100;

  // ---------------------------------------------------------------
  // Register offsets (data-space addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] ADR_FLAGS = 12'h03C;
  localparam logic [11:0] ADR_GPR0 = 12'h03E;
  localparam logic [11:0] ADR_CTRL = 12'h03F;
  localparam logic [11:0] ADR_VALUE = 12'h040;
  localparam logic [11:0] ADR_PTR_LO = 12'h041;
  localparam logic [11:0] ADR_PTR_HI = 12'h042;
  localparam logic [11:0] ADR_GPR1 = 12'h04A;
  localparam logic [11:0] ADR_GPR2 = 12'h04B;
  localparam logic [11:0] ADR_REFUSED = 12'h060;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTL_READ = 0;
  localparam int CTL_PROG = 1;
  localparam int CTL_ARM = 2;
  localparam int CTL_IRQEN = 3;
  localparam int CTL_SEL = 4;
  localparam int FLG_DONE = 0;
  localparam int FLG_REFUSED = 1;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] READ_STALL = 3'h4;
  localparam logic [2:0] PROG_STALL = 3'h2;
  localparam logic [2:0] SRAM_STALL = 3'h1;
  localparam int ATOMIC_US = 3400;
  localparam int SPLIT_US = 1800;
  localparam int OSC_KHZ = 8000;

  typedef enum logic [1:0] {
    SEL_ATOMIC = 2'b00,
    SEL_ERASE = 2'b01,
    SEL_WRITE = 2'b10,
    SEL_RSVD = 2'b11
  } eeio_sel_t;

  typedef enum logic [1:0] {
    BOP_BYTE = 2'b00,
    BOP_SET = 2'b01,
    BOP_CLR = 2'b10,
    BOP_TEST = 2'b11
  } eeio_bop_t;

  typedef struct packed {
    logic io_space;
    eeio_bop_t bop;
    logic [2:0] bit_sel;
    logic [11:0] addr;
    logic [7:0] wdata;
  } eeio_bus_t;

  // Oscillator ticks for a programming time in microseconds
  function automatic int osc_ticks(input int us);
    return (us * OSC_KHZ + 999) / 1000;
  endfunction : osc_ticks

endpackage : eeio_pkg

`default_nettype wire

// ### test_eeprom_access_and_io_space.sv
// Self-checking bench of the byte store access block
`default_nettype none

module test_eeprom_access_and_io_space;
  timeunit 1ns;
  timeprecision 100ps;

  // Short programming counts keep the run brief
  localparam int AT = 16;
  localparam int ST = 8;
  localparam logic [11:0] IOF = eeio_pkg::IO_DATA_OFFSET;
  localparam logic [11:0] CT = eeio_pkg::ADR_CTRL - IOF;
  localparam logic [11:0] VA = eeio_pkg::ADR_VALUE - IOF;
  localparam logic [11:0] PL = eeio_pkg::ADR_PTR_LO - IOF;
  localparam logic [11:0] PH = eeio_pkg::ADR_PTR_HI - IOF;
  localparam logic [11:0] FL = eeio_pkg::ADR_FLAGS - IOF;
  localparam logic [11:0] G0 = eeio_pkg::ADR_GPR0 - IOF;

  logic clock_i, resetn_i, por_ni, osc_clk_i, bus_wr_i, bus_rd_i;
  logic stall_o, irq, supply_ok;
  eeio_pkg::eeio_bus_t bus_req_i;
  logic [7:0] bus_rdata_o, q, d, v;
  logic [8:0] a;
  logic [7:0] mem [512];
  int err_count, n_compared, cyc;

  eeio_ctrl #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .por_ni(por_ni),
    .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_req_i(bus_req_i),
    .bus_rdata_o(bus_rdata_o), .stall_o(stall_o),
    .nvm_ready_irq_o(irq), .osc_clk_i(osc_clk_i), .supply_ok_i(supply_ok));

  eeio_core_model core (
    .clock_i(clock_i), .bus_wr_o(bus_wr_i), .bus_rd_o(bus_rd_i),
    .bus_req_o(bus_req_i), .bus_rdata_i(bus_rdata_o), .stall_i(stall_o));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // Oscillator at 8 MHz, phase unrelated to the CPU clock
  initial begin
    osc_clk_i = 1'b0;
    #3;
    forever #62.5 osc_clk_i = ~osc_clk_i;
  end

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // Checks and bus helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  task automatic chkn(input string nm, input int e, input int g);
    n_compared++;
    if (g != e) begin
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
      err_count++;
    end
  endtask : chkn

  task automatic wio(input logic [11:0] ad, input logic [7:0] dv);
    core.acc(1'b1, 1'b1, 2'h0, 3'h0, ad, dv, q);
  endtask : wio

  task automatic rio(input logic [11:0] ad, output logic [7:0] r);
    core.acc(1'b0, 1'b1, 2'h0, 3'h0, ad, 8'h00, r);
  endtask : rio

  function automatic logic [7:0] exp_prog(input logic [1:0] s,
      input logic [7:0] old, input logic [7:0] dv);
    case (s)
      2'h0: return dv;
      2'h1: return 8'hFF;
      2'h2: return old & dv;
      default: return old;
    endcase
  endfunction : exp_prog

  task automatic prog(input logic [1:0] s, input logic [8:0] ad,
      input logic [7:0] dv, input logic ie);
    wio(CT, {2'h0, s, 4'h0});
    wio(PL, ad[7:0]);
    wio(PH, {7'h00, ad[8]});
    wio(VA, dv);
    wio(CT, {2'h0, s, ie, 3'h4});
    wio(CT, {2'h0, s, ie, 3'h2});
  endtask : prog

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rio(CT, q);
      n++;
    end while (q[1] !== 1'b0 && n < 300);
    chk("busy end", 8'h00, {7'h00, q[1]});
  endtask : wait_idle

  task automatic rbyte(input logic [8:0] ad, output logic [7:0] r);
    wio(PL, ad[7:0]);
    wio(PH, {7'h00, ad[8]});
    core.acc(1'b1, 1'b1, 2'h1, 3'h0, CT, 8'h00, r);
    chkn("read stall", 4, core.stall_n);
    rio(VA, r);
  endtask : rbyte

  task automatic summarize();
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    err_count = 0;
    n_compared = 0;
    cyc = 0;
    resetn_i = 1'b0;
    por_ni = 1'b0;
    supply_ok = 1'b1;
    void'($urandom(32'h499F0437));
    for (int i = 0; i < 512; i++) mem[i] = 8'h00;
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    por_ni <= 1'b1;
    rio(CT, q);
    chk("ctrl reset", 8'h00, q);
    for (int i = 0; i < 3; i++) begin
      if (i < 3) begin
        a[3:0] = (i == 0) ? 4'hE : ((i == 1) ? 4'hA : 4'hB);
        d = $urandom;
        wio({8'h00, (i == 0) ? 4'h1 : 4'h2, a[3:0]}, d);
        core.acc(1'b0, 1'b0, 2'h0, 3'h0,
            {8'h00, (i == 0) ? 4'h1 : 4'h2, a[3:0]} + IOF, 8'h00, q);
        chk("gpr via data space", d, q);
      end
    end
    wio(G0, 8'h0F);
    core.acc(1'b1, 1'b1, 2'h1, 3'h6, G0, 8'h00, q);
    core.acc(1'b1, 1'b1, 2'h2, 3'h1, G0, 8'h00, q);
    core.acc(1'b1, 1'b1, 2'h1, 3'h0, 12'h02A, 8'h00, q);
    rio(G0, q);
    chk("gpr bit ops", 8'h4D, q);
    core.acc(1'b0, 1'b1, 2'h3, 3'h6, G0, 8'h00, q);
    chk("bit test", 8'h01, q);
    core.acc(1'b0, 1'b1, 2'h0, 3'h0, 12'h060, 8'h00, q);
    chk("ext via port op", 8'h01, q);
    core.acc(1'b0, 1'b0, 2'h0, 3'h0, eeio_pkg::ADR_REFUSED, 8'h00, q);
    chk("ext via data space", 8'h00, q);
    d = $urandom;
    core.acc(1'b1, 1'b0, 2'h0, 3'h0, 12'h105, d, q);
    chkn("sram stall", 1, core.stall_n);
    core.acc(1'b0, 1'b0, 2'h0, 3'h0, 12'h105, 8'h00, q);
    chk("sram data", d, q);
    // Every select code on one byte, refusals while the first runs
    a = $urandom;
    for (int s = 0; s < 4; s++) begin
      d = $urandom;
      prog(s[1:0], a, d, 1'b1);
      if (s != 3) chkn("prog stall", 2, core.stall_n);
      rio(CT, q);
      chk("busy bit", (s != 3) ? 8'h01 : 8'h00, {7'h00, q[1]});
      if (s == 0) begin
        chk("irq busy", 8'h00, {7'h00, irq});
        wio(PL, ~a[7:0]);
        core.acc(1'b1, 1'b1, 2'h1, 3'h0, CT, 8'h00, q);
        rio(PL, q);
        chk("pointer held", a[7:0], q);
        rio(VA, q);
        chk("value held", d, q);
        core.acc(1'b0, 1'b0, 2'h0, 3'h0, eeio_pkg::ADR_REFUSED, 8'h00, q);
        chk("refusals", 8'h02, q);
        wio(CT, 8'h1A);
        rio(CT, q);
        chk("select held", 8'h00, {6'h00, q[5:4]});
      end
      wait_idle();
      if (s == 0) begin
        chk("irq ready", 8'h01, {7'h00, irq});
        rio(FL, q);
        chk("flags set", 8'h03, q);
        wio(FL, 8'h00);
        rio(FL, q);
        chk("flags zero write", 8'h03, q);
        wio(FL, 8'h01);
        rio(FL, q);
        chk("flags clear", 8'h02, q);
        core.acc(1'b1, 1'b1, 2'h1, 3'h1, FL, 8'h00, q);
        rio(FL, q);
        chk("flag bit clear", 8'h00, q);
      end
      mem[a] = exp_prog(s[1:0], mem[a], d);
      rbyte(a, v);
      chk("stored byte", mem[a], v);
    end
    // Strobe without arm, and after the arm window
    wio(CT, 8'h02);
    rio(CT, q);
    chk("unarmed", 8'h00, q);
    wio(CT, 8'h04);
    rio(CT, q);
    chk("arm set", 8'h04, q);
    repeat (6) @(posedge clock_i);
    rio(CT, q);
    chk("arm expired", 8'h00, q);
    wio(CT, 8'h02);
    rio(CT, q);
    chk("late strobe", 8'h00, q);
    // System reset in mid programming
    a = $urandom;
    d = $urandom;
    prog(2'h0, a, d, 1'b0);
    @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    rio(CT, q);
    chk("busy over reset", 8'h02, q);
    wait_idle();
    mem[a] = d;
    rbyte(a, v);
    chk("byte after reset", mem[a], v);
    // Supply lost in mid erase leaves the byte as it was
    prog(2'h1, a, 8'h00, 1'b0);
    @(posedge clock_i);
    supply_ok <= 1'b0;
    repeat (4) @(posedge clock_i);
    supply_ok <= 1'b1;
    wait_idle();
    rbyte(a, v);
    chk("byte after supply loss", mem[a], v);
    summarize();
  end

endmodule : test_eeprom_access_and_io_space

`default_nettype wire
